// ---- tb/ppsc_pins_model.sv ----
// board model: pins with pull-ups, driven level when the block enables a pin
// assumes every port pin has a pull-up to the high level on the board
`timescale 1ns/1ps
module ppsc_pins_model #(
   parameter logic [7:0] PULL_LVL = 8'hff
) (
   input  wire logic [7:0] p2_out,
   input  wire logic [7:0] p2_oe,
   input  wire logic [7:0] p3_out,
   input  wire logic [7:0] p3_oe,
   input  wire logic [7:0] p7_out,
   input  wire logic [7:0] p7_oe,
   input  wire logic [7:0] p8_out,
   input  wire logic [7:0] p8_oe,
   input  wire logic [7:0] p9_out,
   input  wire logic [7:0] p9_oe,
   output logic [7:0]      p2_lvl,
   output logic [7:0]      p3_lvl,
   output logic [7:0]      p7_lvl,
   output logic [7:0]      p8_lvl,
   output logic [7:0]      p9_lvl
);
   // a switch keeps the transceiver in normal mode from power-up on
   logic transceiver_standby_pin = 1'b0;
   // a floated pin is pulled, a driven pin shows the drive value
   assign p2_lvl = (p2_oe & p2_out) | (~p2_oe & PULL_LVL);
   assign p3_lvl = (p3_oe & p3_out) | (~p3_oe & PULL_LVL);
   assign p7_lvl = (p7_oe & p7_out) | (~p7_oe & PULL_LVL);
   assign p8_lvl = (p8_oe & p8_out) | (~p8_oe & PULL_LVL);
   assign p9_lvl = (p9_oe & p9_out) | (~p9_oe & PULL_LVL);
endmodule

// ---- tb/ppsc_top_tb_top.sv ----
// self-checking bench for the port pin-state control block
// assumes the pins model above and the 8-bit register port of the block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fails++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module ppsc_top_tb_top;
   typedef struct packed { logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp; } ppsc_row_t;
   logic       clk_sys = 1'b0;
   logic       nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic       nmi_n = 1'b1;
   logic [7:0] reg_rdata, rd_v;
   logic [7:0] p2_in, p2_out, p2_oe, p3_in, p3_out, p3_oe, p7_in, p7_out, p7_oe;
   logic [7:0] p8_in, p8_out, p8_oe, p9_in, p9_out, p9_oe;
   int         fails = 0;
   int         samples_checked = 0;
   // direction before data on ports 2 and 3 only: output bits read the latch, input bits the pulled-up pin
   ppsc_row_t  rows[8] = '{'{8'h04, 8'h3c, 8'h3c}, '{8'h00, 8'ha5, 8'he7},
      '{8'h0c, 8'hc3, 8'hc3}, '{8'h08, 8'h5a, 8'h7e}, '{8'h1c, 8'h96, 8'hff},
      '{8'h24, 8'h69, 8'hff}, '{8'h2c, 8'h0f, 8'hff}, '{8'h3c, 8'h77, 8'h00}};
   // clock at 100 MHz
   always #5 clk_sys = ~clk_sys;
   ppsc_top i_ppsc_top (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .nmi_n(nmi_n), .port2_in(p2_in), .port2_out(p2_out), .port2_oe(p2_oe),
      .port3_in(p3_in), .port3_out(p3_out), .port3_oe(p3_oe), .port7_in(p7_in),
      .port7_out(p7_out), .port7_oe(p7_oe), .port8_in(p8_in), .port8_out(p8_out),
      .port8_oe(p8_oe), .port9_in(p9_in), .port9_out(p9_out), .port9_oe(p9_oe));
   ppsc_pins_model i_ppsc_pins_model (.p2_out(p2_out), .p2_oe(p2_oe), .p3_out(p3_out),
      .p3_oe(p3_oe), .p7_out(p7_out), .p7_oe(p7_oe), .p8_out(p8_out), .p8_oe(p8_oe),
      .p9_out(p9_out), .p9_oe(p9_oe), .p2_lvl(p2_in), .p3_lvl(p3_in), .p7_lvl(p7_in),
      .p8_lvl(p8_in), .p9_lvl(p9_in));
   // one-cycle write; returns just after the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   // one-cycle read; data taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // counts, then the verdict, then the end of the run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      // all pins float while reset is held
      repeat (2) @(posedge clk_sys);
      `CHK("p7_oe_rst", 8'h00, p7_oe)
      `CHK("p3_oe_rst", 8'h00, p3_oe)
      nrst <= 1'b1;
      // eight addresses, unmapped 8'h3c among them, each written by a single byte move, then read back
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rd_v);
         `CHK("readback", rows[i].exp, rd_v)
      end
      `CHK("p2_oe", 8'h3c, p2_oe)
      `CHK("p2_out", 8'ha5, p2_out)
      // forced cutoff of the motor pins on a low nmi level
      wr(8'h20, 8'hff);
      wr(8'h28, 8'hff);
      wr(8'h14, 8'h02);
      @(posedge clk_sys);
      nmi_n <= 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK("p7_oe_cut", 8'hc3, p7_oe)
      `CHK("p8_oe_cut", 8'hfc, p8_oe)
      `CHK("p7_pin_cut", 8'hbe, p7_in)
      `CHK("p8_pin_cut", 8'h6b, p8_in)
      rd(8'h34, rd_v);
      `CHK("status_cut", 8'h01, rd_v)
      wr(8'h14, 8'h00);
      `CHK("p7_oe_nocut", 8'hff, p7_oe)
      @(posedge clk_sys);
      nmi_n <= 1'b1;
      // serial float bit releases port 9 bit 2 only
      wr(8'h30, 8'hff);
      wr(8'h18, 8'h04);
      `CHK("p9_oe_float", 8'hfb, p9_oe)
      `CHK("p9_pin_float", 8'h0f | 8'h04, p9_in)
      wr(8'h18, 8'h00);
      `CHK("p9_oe_drive", 8'hff, p9_oe)
      // leaving single-chip mode with the upper bus bit set
      wr(8'h0c, 8'h00);
      for (int m = 0; m < 2; m++) begin
         wr(8'h10, 8'h08);
         `CHK("p3_oe_nopulse", 4'h0, p3_oe[7:4])
         wr(8'h10, (m == 0) ? 8'h09 : 8'h0b);
         `CHK("p3_oe_pulse", 4'hf, p3_oe[7:4])
         `CHK("p3_out_pulse", 4'h0, p3_out[7:4])
         `CHK("p3_pin_pulse", 4'h0, p3_in[7:4])
         rd(8'h08, rd_v);
         `CHK("p3_data_bus", {ppsc_pkg::UNDEF_NIBBLE, 4'hf}, rd_v)
         rd(8'h0c, rd_v);
         `CHK("p3_dir_bus", {ppsc_pkg::UNDEF_NIBBLE, 4'h0}, rd_v)
      end
      // reset in mid-run: pins float again and the mode register clears
      @(posedge clk_sys);
      nrst <= 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK("p7_oe_rst2", 8'h00, p7_oe)
      `CHK("p3_out_rst2", 8'h00, p3_out)
      @(posedge clk_sys);
      nrst <= 1'b1;
      rd(8'h10, rd_v);
      `CHK("mode_rst2", 8'h00, rd_v)
      print_verdict();
   end
endmodule

// ---- verilog/ppsc_pkg.sv ----
// package for the port pin-state control block
// assumes a single 100 MHz system clock; registers reached over a plain port
package ppsc_pkg;

   // register offsets (byte addresses on the plain register port)
   localparam logic [7:0] OFF_PORT2_DATA = 8'h00;
   localparam logic [7:0] OFF_PORT2_DIR  = 8'h04;
   localparam logic [7:0] OFF_PORT3_DATA = 8'h08;
   localparam logic [7:0] OFF_PORT3_DIR  = 8'h0c;
   localparam logic [7:0] OFF_PROC_MODE  = 8'h10;
   localparam logic [7:0] OFF_TIMER_B2SC = 8'h14;
   localparam logic [7:0] OFF_SER3_CTRL  = 8'h18;
   localparam logic [7:0] OFF_PORT7_DATA = 8'h1c;
   localparam logic [7:0] OFF_PORT7_DIR  = 8'h20;
   localparam logic [7:0] OFF_PORT8_DATA = 8'h24;
   localparam logic [7:0] OFF_PORT8_DIR  = 8'h28;
   localparam logic [7:0] OFF_PORT9_DATA = 8'h2c;
   localparam logic [7:0] OFF_PORT9_DIR  = 8'h30;
   localparam logic [7:0] OFF_STATUS     = 8'h34;

   // field positions
   localparam int POS_CUTOFF_EN   = 1;  // nmi_cutoff_enable in timer_b2_special_control
   localparam int POS_SER3_FLOAT  = 2;  // serial3_pin_float_bit in serial3_control_reg
   localparam int POS_UPPER_BUS   = 3;  // port3_upper_bus_bit in processor_mode_reg0 reg
   localparam int POS_MODE_LO     = 0;  // processor_mode_field bits 1:0

   // processor modes
   typedef enum logic [1:0] {
      PPSC_MODE_SINGLE = 2'b00,
      PPSC_MODE_MEMEXP = 2'b01,
      PPSC_MODE_RSVD   = 2'b10,
      PPSC_MODE_MICRO  = 2'b11
   } ppsc_mode_t;

   // reset values
   localparam logic [7:0] RST_PORT = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;

   // value returned for undefined port3 upper bits
   localparam logic [3:0] UNDEF_NIBBLE = 4'ha;

   // forced-low pulse on port3 upper pins: half a bus-clock cycle, rounded up to one whole clk_sys cycle
   localparam int BCLK_NS        = 10;
   localparam int LOW_PULSE_PS   = 5000;
   localparam int LOW_PULSE_CYC  = (LOW_PULSE_PS + BCLK_NS * 1000 - 1) / (BCLK_NS * 1000);

   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ppsc_req_t;

   // pin pair (out, oe) for one 8-bit port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } ppsc_pins_t;

endpackage

// ---- verilog/ppsc_pulse.sv ----
// one-shot low pulse timer for port3 upper pins on a mode change
// assumes trigger is a one-cycle pulse in the clk_sys domain
`timescale 1ns/1ps
module ppsc_pulse (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic trigger,
   output logic      active
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;

   // load on trigger, count down otherwise
   assign cnt_d  = trigger ? 4'(ppsc_pkg::LOW_PULSE_CYC) :
                   (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
   assign active = (cnt_q != 4'h0);

   // counter register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

// ---- verilog/ppsc_top.sv ----
// port pin-state control: ports 2,3,7,8,9 with forced cutoff and mode effects
// assumes synchronous inputs, one clock, register strobes never both high
// Contract
// - nmi low and enable float port7 bits 5..2 and port8 bits 1..0
// - serial3 float bit floats port9 bit2
// - port3 upper bits read undefined in bus modes with the upper-bus bit set
// - mode change from single to a bus mode with upper-bus set drives port3 upper low
`timescale 1ns/1ps
module ppsc_top (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   input  wire logic [7:0]   reg_addr,
   input  wire logic [7:0]   reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic [7:0]        reg_rdata,
   input  wire logic         nmi_n,
   input  wire logic [7:0]   port2_in,
   output logic [7:0]        port2_out,
   output logic [7:0]        port2_oe,
   input  wire logic [7:0]   port3_in,
   output logic [7:0]        port3_out,
   output logic [7:0]        port3_oe,
   input  wire logic [7:0]   port7_in,
   output logic [7:0]        port7_out,
   output logic [7:0]        port7_oe,
   input  wire logic [7:0]   port8_in,
   output logic [7:0]        port8_out,
   output logic [7:0]        port8_oe,
   input  wire logic [7:0]   port9_in,
   output logic [7:0]        port9_out,
   output logic [7:0]        port9_oe
);
   ppsc_pkg::ppsc_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // writable registers, indexed by byte offset
   logic [7:0] p2d_q, p2r_q, p3d_q, p3r_q, pm_q, tb_q, s3_q;
   logic [7:0] p7d_q, p7r_q, p8d_q, p8r_q, p9d_q, p9r_q;
   logic [7:0] rdata_q;

   // address decode shared by write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // control bits
   wire        cutoff_en  = tb_q[ppsc_pkg::POS_CUTOFF_EN];
   wire        ser3_float = s3_q[ppsc_pkg::POS_SER3_FLOAT];
   wire        upper_bus  = pm_q[ppsc_pkg::POS_UPPER_BUS];
   wire [1:0]  mode       = pm_q[ppsc_pkg::POS_MODE_LO +: 2];
   wire        bus_mode   = (mode == ppsc_pkg::PPSC_MODE_MEMEXP) ||
                            (mode == ppsc_pkg::PPSC_MODE_MICRO);
   wire        p3_undef   = bus_mode && upper_bus;
   wire        cutoff     = cutoff_en && !nmi_n;

   // mode-change detection: single-chip to a bus mode with upper-bus set
   wire        pm_wr      = req.wr && hit(req.addr, ppsc_pkg::OFF_PROC_MODE);
   wire [1:0]  new_mode   = req.wdata[ppsc_pkg::POS_MODE_LO +: 2];
   wire        new_bus    = (new_mode == ppsc_pkg::PPSC_MODE_MEMEXP) ||
                            (new_mode == ppsc_pkg::PPSC_MODE_MICRO);
   wire        low_trig   = pm_wr && (mode == ppsc_pkg::PPSC_MODE_SINGLE) && new_bus &&
                            (upper_bus || req.wdata[ppsc_pkg::POS_UPPER_BUS]);
   wire        low_active;

   ppsc_pulse u_pulse (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .trigger (low_trig),
      .active  (low_active)
   );

   // register writes; software is expected to use whole moves
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         p2d_q <= ppsc_pkg::RST_PORT;
         p2r_q <= ppsc_pkg::RST_PORT;
         p3d_q <= ppsc_pkg::RST_PORT;
         p3r_q <= ppsc_pkg::RST_PORT;
         pm_q  <= ppsc_pkg::RST_CTRL;
         tb_q  <= ppsc_pkg::RST_CTRL;
         s3_q  <= ppsc_pkg::RST_CTRL;
         p7d_q <= ppsc_pkg::RST_PORT;
         p7r_q <= ppsc_pkg::RST_PORT;
         p8d_q <= ppsc_pkg::RST_PORT;
         p8r_q <= ppsc_pkg::RST_PORT;
         p9d_q <= ppsc_pkg::RST_PORT;
         p9r_q <= ppsc_pkg::RST_PORT;
      end else if (req.wr) begin
         if (hit(req.addr, ppsc_pkg::OFF_PORT2_DATA)) p2d_q <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_PORT2_DIR))  p2r_q <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_PORT3_DATA)) p3d_q <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_PORT3_DIR))  p3r_q <= req.wdata;
         if (pm_wr)                                    pm_q  <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_TIMER_B2SC)) tb_q  <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_SER3_CTRL))  s3_q  <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_PORT7_DATA)) p7d_q <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_PORT7_DIR))  p7r_q <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_PORT8_DATA)) p8d_q <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_PORT8_DIR))  p8r_q <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_PORT9_DATA)) p9d_q <= req.wdata;
         if (hit(req.addr, ppsc_pkg::OFF_PORT9_DIR))  p9r_q <= req.wdata;
      end
   end

   // pin views: output pins read back the latch, input pins the pin level
   wire [7:0] p2_view = (p2r_q & p2d_q) | (~p2r_q & port2_in);
   wire [7:0] p3_view = (p3r_q & p3d_q) | (~p3r_q & port3_in);
   wire [7:0] p7_view = (p7r_q & p7d_q) | (~p7r_q & port7_in);
   wire [7:0] p8_view = (p8r_q & p8d_q) | (~p8r_q & port8_in);
   wire [7:0] p9_view = (p9r_q & p9d_q) | (~p9r_q & port9_in);
   wire [7:0] p3_rd   = p3_undef ? {ppsc_pkg::UNDEF_NIBBLE, p3_view[3:0]} : p3_view;
   wire [7:0] p3r_rd  = p3_undef ? {ppsc_pkg::UNDEF_NIBBLE, p3r_q[3:0]}   : p3r_q;
   wire [7:0] status  = {6'h00, low_active, cutoff};

   // read mux; unmapped addresses read zero
   wire [7:0] rd_mux =
      hit(req.addr, ppsc_pkg::OFF_PORT2_DATA) ? p2_view :
      hit(req.addr, ppsc_pkg::OFF_PORT2_DIR)  ? p2r_q   :
      hit(req.addr, ppsc_pkg::OFF_PORT3_DATA) ? p3_rd   :
      hit(req.addr, ppsc_pkg::OFF_PORT3_DIR)  ? p3r_rd  :
      hit(req.addr, ppsc_pkg::OFF_PROC_MODE)  ? pm_q    :
      hit(req.addr, ppsc_pkg::OFF_TIMER_B2SC) ? tb_q    :
      hit(req.addr, ppsc_pkg::OFF_SER3_CTRL)  ? s3_q    :
      hit(req.addr, ppsc_pkg::OFF_PORT7_DATA) ? p7_view :
      hit(req.addr, ppsc_pkg::OFF_PORT7_DIR)  ? p7r_q   :
      hit(req.addr, ppsc_pkg::OFF_PORT8_DATA) ? p8_view :
      hit(req.addr, ppsc_pkg::OFF_PORT8_DIR)  ? p8r_q   :
      hit(req.addr, ppsc_pkg::OFF_PORT9_DATA) ? p9_view :
      hit(req.addr, ppsc_pkg::OFF_PORT9_DIR)  ? p9r_q   :
      hit(req.addr, ppsc_pkg::OFF_STATUS)     ? status  : 8'h00;

   // read data register, valid only the cycle after the strobe
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= req.rd ? rd_mux : 8'h00;
      end
   end
   assign reg_rdata = rdata_q;

   // pin drivers
   localparam logic [7:0] P7_CUT = 8'h3c; // port7 bits 5..2
   localparam logic [7:0] P8_CUT = 8'h03; // port8 bits 1..0
   localparam logic [7:0] P9_FLT = 8'h04; // port9 bit 2
   localparam logic [7:0] P3_HI  = 8'hf0; // port3 bits 7..4

   assign port2_out = p2d_q;
   assign port2_oe  = p2r_q;
   assign port3_out = low_active ? (p3d_q & ~P3_HI) : p3d_q;
   assign port3_oe  = low_active ? (p3r_q | P3_HI)  : p3r_q;
   assign port7_out = p7d_q;
   assign port7_oe  = cutoff ? (p7r_q & ~P7_CUT) : p7r_q;
   assign port8_out = p8d_q;
   assign port8_oe  = cutoff ? (p8r_q & ~P8_CUT) : p8r_q;
   assign port9_out = p9d_q;
   assign port9_oe  = ser3_float ? (p9r_q & ~P9_FLT) : p9r_q;

   // assertions
   property p_cutoff;
      @(posedge clk_sys) disable iff (!nrst)
      (cutoff_en && !nmi_n) |-> ((port7_oe & P7_CUT) == 8'h00 && (port8_oe & P8_CUT) == 8'h00);
   endproperty
   a_cutoff: assert property (p_cutoff) else $error("cutoff pins still driven");

   property p_float9;
      @(posedge clk_sys) disable iff (!nrst)
      (req.wr && hit(req.addr, ppsc_pkg::OFF_SER3_CTRL) && req.wdata[ppsc_pkg::POS_SER3_FLOAT])
      |=> (port9_oe[2] == 1'b0);
   endproperty
   a_float9: assert property (p_float9) else $error("port9 bit2 not floated");

   property p_undef;
      @(posedge clk_sys) disable iff (!nrst)
      (req.rd && hit(req.addr, ppsc_pkg::OFF_PORT3_DIR) && p3_undef)
      |=> (reg_rdata[7:4] == ppsc_pkg::UNDEF_NIBBLE);
   endproperty
   a_undef: assert property (p_undef) else $error("port3 upper not undefined");

   sequence s_enter_bus;
      low_trig;
   endsequence
   property p_lowpulse;
      @(posedge clk_sys) disable iff (!nrst)
      s_enter_bus |=> (port3_oe[7:4] == 4'hf && port3_out[7:4] == 4'h0) ##1 !low_active;
   endproperty
   a_lowpulse: assert property (p_lowpulse) else $error("port3 low pulse wrong");

   // no pulse may start without a qualifying mode change
   property p_nopulse;
      @(posedge clk_sys) disable iff (!nrst)
      (!low_trig && !low_active) |=> !low_active;
   endproperty
   a_nopulse: assert property (p_nopulse) else $error("port3 low pulse unprompted");

   // float bit releases bit 2 only, the other port9 bits follow direction
   property p_float9_hold;
      @(posedge clk_sys) disable iff (!nrst)
      ser3_float |-> (port9_oe == (p9r_q & ~P9_FLT));
   endproperty
   a_float9_hold: assert property (p_float9_hold) else $error("port9 enables wrong");

   // without enable or with nmi high the motor pins follow direction
   property p_cut_release;
      @(posedge clk_sys) disable iff (!nrst)
      (!cutoff_en || nmi_n) |-> ((port7_oe & P7_CUT) == (p7r_q & P7_CUT) &&
                                 (port8_oe & P8_CUT) == (p8r_q & P8_CUT));
   endproperty
   a_cut_release: assert property (p_cut_release) else $error("motor pins cut");

   // port3 data upper bits also read the undefined nibble in bus modes with upper-bus set
   property p_undef_data;
      @(posedge clk_sys) disable iff (!nrst)
      (req.rd && hit(req.addr, ppsc_pkg::OFF_PORT3_DATA) && p3_undef)
      |=> (reg_rdata[7:4] == ppsc_pkg::UNDEF_NIBBLE);
   endproperty
   a_undef_data: assert property (p_undef_data) else $error("port3 data upper defined");

   // outside bus modes the direction register reads back whole
   property p_dir_defined;
      @(posedge clk_sys) disable iff (!nrst)
      (req.rd && hit(req.addr, ppsc_pkg::OFF_PORT3_DIR) && !p3_undef)
      |=> (reg_rdata == $past(p3r_q));
   endproperty
   a_dir_defined: assert property (p_dir_defined) else $error("port3 dir read wrong");
endmodule
